// ==== bench/i2c_master_model.sv ====
// Two-wire bus master model clocked by the link clock.
module i2c_master_model (
	// Link clock
	input wire logic lclk,
	// Wire level and master drive
	input wire logic sda,
	output logic scl,
	output logic sda_drv
);
	timeunit 1ns;
	timeprecision 1ps;

	// only the master moves the clock
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// data moves only while clock low
	task automatic bit_io(input logic b, output logic r);
		@(posedge lclk);
		sda_drv = b;
		@(posedge lclk);
		scl = 1'b1;
		@(posedge lclk);
		r = sda;
		@(posedge lclk);
		scl = 1'b0;
	endtask

	task automatic start();
		@(posedge lclk);
		sda_drv = 1'b1;
		@(posedge lclk);
		scl = 1'b1;
		@(posedge lclk);
		sda_drv = 1'b0;
		@(posedge lclk);
		scl = 1'b0;
	endtask

	task automatic stop();
		@(posedge lclk);
		sda_drv = 1'b0;
		@(posedge lclk);
		scl = 1'b1;
		@(posedge lclk);
		sda_drv = 1'b1;
		@(posedge lclk);
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask

	// master acknowledges or ends the read
	task automatic rbyte(output logic [7:0] d, input logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(!ack, r);
	endtask
endmodule

// ==== bench/sensor_i2c_monitor.sv ====
// Port checker for the sensor serial slave and store loader.
module sensor_i2c_monitor #(
	parameter int POR_CYCLES = 150000,
	parameter int PROG_CYCLES = 700000
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Serial pins
	input wire logic SCL_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	// Status
	input wire logic [15:0] CONFIG_WORD,
	input wire logic NVM_BUSY,
	input wire logic NVM_UNLOCKED
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MIN_BUSY = (POR_CYCLES < PROG_CYCLES) ? POR_CYCLES : PROG_CYCLES;
	localparam int MAX_BUSY = ((POR_CYCLES > PROG_CYCLES) ? POR_CYCLES : PROG_CYCLES) + 8;
	int busy_cnt_reg;
	int oe_cnt_reg;

	// Long spans are counted here, since repetition counts must stay small.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			busy_cnt_reg <= 0;
		else if (NVM_BUSY)
			busy_cnt_reg <= busy_cnt_reg + 1;
		else
			busy_cnt_reg <= 0;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			oe_cnt_reg <= 0;
		else if (SDA_OE)
			oe_cnt_reg <= oe_cnt_reg + 1;
		else
			oe_cnt_reg <= 0;
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	a_sda_only_low: assert property (SDA_OE |-> !SDA_OUT)
		else $error("Data line driven high.");
	a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_IN)
		else $error("Data drive changed while clock high.");
	a_ack_hold: assert property ($rose(SDA_OE) |-> SDA_OE [*8])
		else $error("Low drive released too early.");
	a_oe_bounded: assert property (oe_cnt_reg <= 300)
		else $error("Data line held low too long.");
	a_busy_at_rst: assert property ($rose(RST_N) |-> NVM_BUSY [*8])
		else $error("Busy not shown after reset.");
	a_busy_span: assert property ($fell(NVM_BUSY) |->
		busy_cnt_reg >= MIN_BUSY - 4 && busy_cnt_reg <= MAX_BUSY)
		else $error("Busy span out of range.");
	a_busy_cap: assert property (busy_cnt_reg <= MAX_BUSY)
		else $error("Busy stuck high.");
	a_relock_load: assert property ($fell(NVM_UNLOCKED) |-> ##[0:8] NVM_BUSY)
		else $error("Relock without reload.");
	a_cfg_busy: assert property (NVM_BUSY [*3] |-> CONFIG_WORD[12])
		else $error("Config busy bit not set.");

	c_ack: cover property ($rose(SDA_OE));
	c_relock: cover property ($fell(NVM_UNLOCKED));
	c_prog: cover property ($rose(NVM_BUSY));
endmodule

// ==== bench/sensor_i2c_slave_nvm_loader_test.sv ====
// Self-checking bench for the sensor serial slave and store loader.
module sensor_i2c_slave_nvm_loader_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int POR_N = 3000;
	localparam int PROG_N = 3000;
	logic clk, rst_n, lclk, scl, sda_drv, sda, strap, oe, so, busy, unl;
	logic [1:0] strap_sel;
	logic [15:0] temp, cfg, hi, lo;
	int fail_count, cmp_count;

	always #5 clk = ~clk;
	always #40 lclk = ~lclk;
	assign sda = sda_drv & (oe ? so : 1'b1);
	assign strap = (strap_sel == 2'h0) ? 1'b0 : (strap_sel == 2'h1) ? 1'b1 :
		(strap_sel == 2'h2) ? sda : scl;

	i2c_master_model m (.lclk(lclk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

	sensor_i2c_slave_nvm_loader #(.POR_CYCLES(POR_N), .PROG_CYCLES(PROG_N)) dut (
		.CLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(so), .SDA_OE(oe),
		.ADDRESS_STRAP_PIN(strap), .TEMP_RESULT(temp), .CONFIG_WORD(cfg),
		.HIGH_LIMIT(hi), .LOW_LIMIT(lo), .NVM_BUSY(busy), .NVM_UNLOCKED(unl));

	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic close_out();
		if (fail_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic pause(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wbyte(input logic [7:0] d, input logic e);
		logic a;
		m.wbyte(d, a);
		chk("ack", {15'h0, e}, {15'h0, a});
	endtask

	task automatic wr_reg(input logic [7:0] p, input logic [15:0] v, input int nb);
		m.start();
		wbyte(8'h90, 1'b1);
		wbyte(p, 1'b1);
		if (nb > 0)
			wbyte(v[15:8], 1'b1);
		if (nb > 1)
			wbyte(v[7:0], 1'b1);
		m.stop();
		pause(10);
	endtask

	task automatic rd_reg(output logic [15:0] v);
		m.start();
		wbyte(8'h91, 1'b1);
		m.rbyte(v[15:8], 1'b1);
		m.rbyte(v[7:0], 1'b0);
		m.stop();
		pause(10);
	endtask

	task automatic chk_rd(input string name, input logic [15:0] e);
		logic [15:0] v;
		rd_reg(v);
		chk(name, e, v);
	endtask

	task automatic gc(input logic [7:0] c, input logic e);
		m.start();
		wbyte(8'h00, 1'b1);
		wbyte(c, e);
		m.stop();
		pause(10);
	endtask

	// Bounded wait, so a stuck flag shows as a mismatch rather than a hang.
	task automatic wait_busy();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		chk("busy_wait", 16'h0, {15'h0, busy});
	endtask

	task automatic t_por();
		chk_rd("temp", 16'h1a2b);
		wr_reg(8'h02, 16'h1234, 2);
		chk("busy_load", 16'h1, {15'h0, busy});
		wait_busy();
		chk("high_por", tsens_pkg::HIGH_RESET, hi);
		chk("cfg_por", tsens_pkg::CONFIG_RESET, cfg);
	endtask

	task automatic t_addr();
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			strap_sel <= k[1:0];
			m.start();
			wbyte({5'h12, k[1:0], 1'b0}, 1'b1);
			m.stop();
			m.start();
			wbyte({5'h12, ~k[1:0], 1'b0}, 1'b0);
			m.stop();
		end
		@(posedge clk);
		strap_sel <= 2'h0;
	endtask

	task automatic t_word();
		wr_reg(8'h02, 16'h1234, 2);
		chk("high_wr", 16'h1234, hi);
		chk_rd("rd1", 16'h1234);
		chk_rd("rd2", 16'h1234);
		wr_reg(8'h03, 16'h5678, 2);
		wr_reg(8'h03, 16'hab00, 1);
		chk("low_half", 16'hab78, lo);
		wr_reg(8'h01, 16'h0aa0, 2);
		chk("cfg_alias", 16'h02a0, cfg);
		chk_rd("cfg_rd", 16'h02a0);
		wr_reg(8'h0f, 16'h0000, 0);
		chk_rd("dev_id", tsens_pkg::DEVICE_ID_DEF);
		wr_reg(8'h04, 16'h0000, 0);
		chk_rd("unlock_rd", 16'h0000);
	endtask

	task automatic t_prog();
		logic [15:0] v;
		int n;
		gc(8'h06, 1'b1);
		wait_busy();
		chk("cfg_relock", tsens_pkg::CONFIG_RESET, cfg);
		chk("high_relock", tsens_pkg::HIGH_RESET, hi);
		chk("low_relock", tsens_pkg::LOW_RESET, lo);
		gc(8'h05, 1'b0);
		wr_reg(8'h04, 16'h8000, 2);
		chk("unlocked", 16'h1, {15'h0, unl});
		wr_reg(8'h02, 16'h4321, 2);
		chk("prog_busy", 16'h1, {15'h0, busy});
		wr_reg(8'h04, 16'h0000, 0);
		chk_rd("poll_first", 16'hc000);
		n = 0;
		do begin
			rd_reg(v);
			n++;
		end while (v[14] !== 1'b0 && n < 20);
		chk("poll_end", 16'h8000, v);
		gc(8'h06, 1'b1);
		chk("relocked", 16'h0, {15'h0, unl});
		wait_busy();
		chk("high_nvm", 16'h4321, hi);
		chk_rd("ptr_reset", 16'h1a2b);
	endtask

	initial begin
		clk = 1'b0;
		lclk = 1'b0;
		rst_n = 1'b0;
		strap_sel = 2'h0;
		temp = 16'h1a2b;
		fail_count = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		pause(4);
		t_por();
		t_addr();
		t_word();
		t_prog();
		close_out();
	end

	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		close_out();
	end
endmodule

bind sensor_i2c_slave_nvm_loader sensor_i2c_monitor #(
	.POR_CYCLES(POR_CYCLES), .PROG_CYCLES(PROG_CYCLES)) mon (
	.CLK(CLK), .RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
	.CONFIG_WORD(CONFIG_WORD), .NVM_BUSY(NVM_BUSY), .NVM_UNLOCKED(NVM_UNLOCKED));

// ==== rtl/pin_sync3.sv ====
// Three-stage pin synchroniser whose output moves once the last two stages agree.
module pin_sync3 #(
	parameter logic INIT = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pin and filtered level
	input wire logic pin,
	output logic level
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// A one-cycle glitch never shows in both late stages, so it is filtered.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= INIT;
		end else if (s2_reg == s3_reg) begin
			level <= s3_reg;
		end
	end

endmodule

// ==== rtl/sensor_i2c_slave_nvm_loader.sv ====
// Serial slave front end with register map and non-volatile default loader.
module sensor_i2c_slave_nvm_loader #(
	parameter int POR_CYCLES = tsens_pkg::POR_CYCLES,
	parameter int PROG_CYCLES = tsens_pkg::PROG_CYCLES,
	parameter logic [15:0] DEVICE_ID = tsens_pkg::DEVICE_ID_DEF
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Serial bus pins; the clock line is input only
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	// Address strap pin
	input wire logic ADDRESS_STRAP_PIN,
	// Latest conversion result
	input wire logic [15:0] TEMP_RESULT,
	// Loaded configuration and store status
	output logic [15:0] CONFIG_WORD,
	output logic [15:0] HIGH_LIMIT,
	output logic [15:0] LOW_LIMIT,
	output logic NVM_BUSY,
	output logic NVM_UNLOCKED
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_PTR,
		ST_DATA,
		ST_GC,
		ST_READ,
		ST_SKIP
	} bus_state_t;

	localparam logic [tsens_pkg::CNT_W-1:0] POR_LAST = tsens_pkg::CNT_W'(POR_CYCLES - 1);
	localparam logic [tsens_pkg::CNT_W-1:0] PROG_LAST = tsens_pkg::CNT_W'(PROG_CYCLES - 1);

	logic scl_s;
	logic sda_s;
	logic strap_s;
	logic scl_d_reg;
	logic sda_d_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	bus_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic ack_reg;
	logic byte_sel_reg;
	logic [15:0] rd_latch_reg;
	logic [7:0] byte_hi_reg;
	logic hi_pend_reg;
	logic [7:0] ptr_reg;
	logic wr_req_reg;
	logic [15:0] wr_word_reg;
	logic gc_req_reg;
	logic ne_sda_reg;
	logic ne_scl_reg;
	logic [1:0] own_low;

	logic loading_reg;
	logic [tsens_pkg::CNT_W-1:0] load_cnt_reg;
	logic load_done;
	logic programming_reg;
	logic [tsens_pkg::CNT_W-1:0] prog_cnt_reg;
	logic busy;

	logic [15:0] cfg_reg;
	logic [15:0] high_reg;
	logic [15:0] low_reg;
	logic [15:0] gp_reg [0:3];
	logic eun_reg;
	logic [15:0] nvm_mem [0:tsens_pkg::NVM_WORDS-1];

	logic [15:0] rd_word;
	logic [15:0] cfg_view;
	logic wr_accept;
	logic nvm_hit;
	logic [2:0] nvm_idx;
	logic [7:0] gp_off;

	pin_sync3 #(.INIT(1'b1)) u_scl_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.pin(SCL_IN),
		.level(scl_s)
	);

	pin_sync3 #(.INIT(1'b1)) u_sda_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.pin(SDA_IN),
		.level(sda_s)
	);

	pin_sync3 #(.INIT(1'b0)) u_strap_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.pin(ADDRESS_STRAP_PIN),
		.level(strap_s)
	);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ne_sda_reg <= 1'b0;
			ne_scl_reg <= 1'b0;
		end else if (start_cond) begin
			ne_sda_reg <= 1'b0;
			ne_scl_reg <= 1'b0;
		end else if (state_reg == ST_ADDR) begin
			ne_sda_reg <= ne_sda_reg | (strap_s != sda_s);
			ne_scl_reg <= ne_scl_reg | (strap_s != scl_s);
		end
	end

	// A strap that followed the clock or data line through the whole address byte
	// is taken as tied to that line; the address holds both levels, so a fixed
	// strap always mismatches both.
	always_comb begin
		if (!ne_scl_reg) begin
			own_low = 2'b11;
		end else if (!ne_sda_reg) begin
			own_low = 2'b10;
		end else begin
			own_low = {1'b0, strap_s};
		end
	end

	assign busy = loading_reg | programming_reg;

	always_comb begin
		cfg_view = cfg_reg & tsens_pkg::CFG_WR_MASK;
		if (cfg_reg[tsens_pkg::CFG_MOD_LSB +: 2] == tsens_pkg::MOD_ALIAS_CC) begin
			cfg_view[tsens_pkg::CFG_MOD_LSB +: 2] = 2'b00;
		end
		cfg_view[tsens_pkg::CFG_BUSY_BIT] = busy;
	end

	assign gp_off = ptr_reg - tsens_pkg::PTR_GP1;

	always_comb begin
		rd_word = 16'h0000;
		case (ptr_reg)
			tsens_pkg::PTR_TEMP: rd_word = TEMP_RESULT;
			tsens_pkg::PTR_CONFIG: rd_word = cfg_view;
			tsens_pkg::PTR_HIGH: rd_word = high_reg;
			tsens_pkg::PTR_LOW: rd_word = low_reg;
			tsens_pkg::PTR_UNLOCK: begin
				rd_word[tsens_pkg::UNLOCK_EUN_BIT] = eun_reg;
				rd_word[tsens_pkg::UNLOCK_BUSY_BIT] = busy;
			end
			tsens_pkg::PTR_DEV_ID: rd_word = DEVICE_ID;
			default: begin
				if (ptr_reg >= tsens_pkg::PTR_GP1 && ptr_reg <= tsens_pkg::PTR_GP4) begin
					rd_word = gp_reg[gp_off[1:0]];
				end
			end
		endcase
	end

	// Serial protocol engine; SCL is never driven, only SDA is pulled low.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ack_reg <= 1'b0;
			SDA_OE <= 1'b0;
			byte_sel_reg <= 1'b0;
			rd_latch_reg <= 16'h0000;
			byte_hi_reg <= 8'h00;
			hi_pend_reg <= 1'b0;
			ptr_reg <= tsens_pkg::PTR_RESET;
			wr_req_reg <= 1'b0;
			wr_word_reg <= 16'h0000;
			gc_req_reg <= 1'b0;
		end else begin
			wr_req_reg <= 1'b0;
			gc_req_reg <= 1'b0;
			if (start_cond || stop_cond) begin
				if (hi_pend_reg) begin
					wr_req_reg <= 1'b1;
					wr_word_reg <= {byte_hi_reg, rd_word[7:0]};
				end
				hi_pend_reg <= 1'b0;
				ack_reg <= 1'b0;
				SDA_OE <= 1'b0;
				bit_cnt_reg <= 4'h0;
				state_reg <= start_cond ? ST_ADDR : ST_IDLE;
			end else if (state_reg == ST_READ) begin
				if (scl_rise) begin
					if (bit_cnt_reg == 4'd8 && sda_s) begin
						state_reg <= ST_SKIP;
					end
					if (bit_cnt_reg != 4'd9) begin
						bit_cnt_reg <= bit_cnt_reg + 4'd1;
					end
				end else if (scl_fall) begin
					if (bit_cnt_reg == 4'd9) begin
						tx_reg <= byte_sel_reg ? rd_latch_reg[7:0] : rd_latch_reg[15:8];
						SDA_OE <= byte_sel_reg ? ~rd_latch_reg[7] : ~rd_latch_reg[15];
						byte_sel_reg <= ~byte_sel_reg;
						bit_cnt_reg <= 4'h0;
					end else if (bit_cnt_reg == 4'd8) begin
						SDA_OE <= 1'b0;
					end else begin
						tx_reg <= {tx_reg[6:0], 1'b0};
						SDA_OE <= ~tx_reg[6];
					end
				end
			end else if (state_reg == ST_IDLE || state_reg == ST_SKIP) begin
				SDA_OE <= 1'b0;
			end else if (ack_reg) begin
				if (scl_fall) begin
					ack_reg <= 1'b0;
					SDA_OE <= 1'b0;
					bit_cnt_reg <= 4'h0;
				end
			end else if (scl_rise && bit_cnt_reg < 4'd8) begin
				shift_reg <= {shift_reg[6:0], sda_s};
				bit_cnt_reg <= bit_cnt_reg + 4'd1;
			end else if (scl_fall && bit_cnt_reg == 4'd8) begin
				case (state_reg)
					ST_ADDR: begin
						if (shift_reg[7:1] == {tsens_pkg::ADDR_UPPER, own_low}) begin
							ack_reg <= 1'b1;
							SDA_OE <= 1'b1;
							if (shift_reg[0]) begin
								state_reg <= ST_READ;
								bit_cnt_reg <= 4'd9;
								byte_sel_reg <= 1'b0;
								rd_latch_reg <= rd_word;
							end else begin
								state_reg <= ST_PTR;
							end
						end else if (shift_reg == tsens_pkg::GEN_CALL_ADDR) begin
							ack_reg <= 1'b1;
							SDA_OE <= 1'b1;
							state_reg <= ST_GC;
						end else begin
							state_reg <= ST_SKIP;
						end
					end
					ST_PTR: begin
						ptr_reg <= shift_reg;
						ack_reg <= 1'b1;
						SDA_OE <= 1'b1;
						state_reg <= ST_DATA;
					end
					ST_DATA: begin
						ack_reg <= 1'b1;
						SDA_OE <= 1'b1;
						if (hi_pend_reg) begin
							wr_req_reg <= 1'b1;
							wr_word_reg <= {byte_hi_reg, shift_reg};
							hi_pend_reg <= 1'b0;
						end else begin
							byte_hi_reg <= shift_reg;
							hi_pend_reg <= 1'b1;
						end
					end
					ST_GC: begin
						if (shift_reg == tsens_pkg::GEN_CALL_RESET) begin
							ack_reg <= 1'b1;
							SDA_OE <= 1'b1;
							gc_req_reg <= 1'b1;
							ptr_reg <= tsens_pkg::PTR_RESET;
						end else begin
							// Any other command is not acknowledged; the rest of the transfer is skipped.
							state_reg <= ST_SKIP;
						end
					end
					default: state_reg <= ST_SKIP;
				endcase
			end
		end
	end

	// The open-drain data pin only ever drives low.
	// clock line never driven
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SDA_OUT <= 1'b0;
		end else begin
			SDA_OUT <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			loading_reg <= 1'b1;
			load_cnt_reg <= '0;
		end else if (gc_req_reg) begin
			loading_reg <= 1'b1;
			load_cnt_reg <= '0;
		end else if (loading_reg) begin
			if (load_cnt_reg == POR_LAST) begin
				loading_reg <= 1'b0;
			end
			load_cnt_reg <= load_cnt_reg + 1'b1;
		end
	end

	assign load_done = loading_reg & (load_cnt_reg == POR_LAST) & ~gc_req_reg;

	// drop limit and config writes while loading
	assign wr_accept = wr_req_reg & ~(loading_reg & (ptr_reg == tsens_pkg::PTR_CONFIG
		|| ptr_reg == tsens_pkg::PTR_HIGH || ptr_reg == tsens_pkg::PTR_LOW));

	always_comb begin
		nvm_hit = 1'b1;
		nvm_idx = tsens_pkg::NVM_CFG;
		case (ptr_reg)
			tsens_pkg::PTR_CONFIG: nvm_idx = tsens_pkg::NVM_CFG;
			tsens_pkg::PTR_HIGH: nvm_idx = tsens_pkg::NVM_HIGH;
			tsens_pkg::PTR_LOW: nvm_idx = tsens_pkg::NVM_LOW;
			default: begin
				nvm_hit = ptr_reg >= tsens_pkg::PTR_GP1 && ptr_reg <= tsens_pkg::PTR_GP4;
				nvm_idx = tsens_pkg::NVM_GP1 + {1'b0, gp_off[1:0]};
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			programming_reg <= 1'b0;
			prog_cnt_reg <= '0;
			for (int i = 0; i < tsens_pkg::NVM_WORDS; i++) begin
				nvm_mem[i] <= tsens_pkg::nvm_default(i);
			end
		end else if (programming_reg) begin
			// busy for the whole programming time
			if (prog_cnt_reg == PROG_LAST) begin
				programming_reg <= 1'b0;
			end
			prog_cnt_reg <= prog_cnt_reg + 1'b1;
		end else if (wr_accept && eun_reg && nvm_hit && !loading_reg) begin
			programming_reg <= 1'b1;
			prog_cnt_reg <= '0;
			if (nvm_idx == tsens_pkg::NVM_CFG) begin
				nvm_mem[nvm_idx] <= wr_word_reg & tsens_pkg::CFG_NVM_MASK;
			end else begin
				nvm_mem[nvm_idx] <= wr_word_reg;
			end
		end
	end

	// Volatile registers; the load at the end of reset restores stored defaults.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_reg <= tsens_pkg::CONFIG_RESET;
			high_reg <= tsens_pkg::HIGH_RESET;
			low_reg <= tsens_pkg::LOW_RESET;
			eun_reg <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				gp_reg[i] <= tsens_pkg::GP_RESET;
			end
		end else if (gc_req_reg) begin
			eun_reg <= 1'b0;
		end else if (load_done) begin
			cfg_reg <= nvm_mem[tsens_pkg::NVM_CFG];
			high_reg <= nvm_mem[tsens_pkg::NVM_HIGH];
			low_reg <= nvm_mem[tsens_pkg::NVM_LOW];
			eun_reg <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				gp_reg[i] <= nvm_mem[int'(tsens_pkg::NVM_GP1) + i];
			end
		end else if (wr_accept) begin
			case (ptr_reg)
				tsens_pkg::PTR_CONFIG: cfg_reg <= wr_word_reg & tsens_pkg::CFG_WR_MASK;
				tsens_pkg::PTR_HIGH: high_reg <= wr_word_reg;
				tsens_pkg::PTR_LOW: low_reg <= wr_word_reg;
				tsens_pkg::PTR_UNLOCK: eun_reg <= wr_word_reg[tsens_pkg::UNLOCK_EUN_BIT];
				default: begin
					if (nvm_hit) begin
						gp_reg[gp_off[1:0]] <= wr_word_reg;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			NVM_BUSY <= 1'b1;
			NVM_UNLOCKED <= 1'b0;
			CONFIG_WORD <= tsens_pkg::CONFIG_RESET;
			HIGH_LIMIT <= tsens_pkg::HIGH_RESET;
			LOW_LIMIT <= tsens_pkg::LOW_RESET;
		end else begin
			NVM_BUSY <= busy;
			NVM_UNLOCKED <= eun_reg;
			CONFIG_WORD <= cfg_view;
			HIGH_LIMIT <= high_reg;
			LOW_LIMIT <= low_reg;
		end
	end

endmodule

// ==== rtl/tsens_pkg.sv ====
// Constants shared by the sensor serial slave and its non-volatile store.
// Functional notes
// - Any reset runs a 1.5 ms load of stored defaults into the registers.
// - During that load, writes to limit and configuration registers are dropped.
// - Store holds limits, config defaults and four general-purpose words.
// - Store starts locked; locked writes only change the volatile registers.
// - With unlock bit set, each config, limit or general-purpose write made while not busy also programs the store.
// - Programming one location takes 7 ms with the busy flag set throughout.
// - General-call reset reloads the store, clears unlock and relocks.
// - Busy flag also shows the power-on load while it runs.
// - An 8-bit index pointer selects the register; it resets to zero.
// - The device is slave only and never drives the clock line.
// - Clock rates from 1 kHz to 400 kHz are supported.
// - Own address is 10010 plus two bits decoded from the strap wiring.
// - A matching address byte is acknowledged on the ninth clock.
// - First written byte loads the pointer; later bytes write the register.
// - Reads use the last written pointer, which reads never change.
// - As receiver, address, pointer and data bytes are all acknowledged.
// - As transmitter, upper byte goes first, then the lower byte.
// - A data change while the clock is high is a start or stop.
// - General call is acknowledged; command 06h reloads power-up values.
package tsens_pkg;

	localparam int CLK_MHZ = 100;
	localparam int POR_TIME_US = 1500;
	localparam int PROG_TIME_US = 7000;
	localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam int CNT_W = 20;

	localparam logic [4:0] ADDR_UPPER = 5'h12;
	localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
	localparam logic [7:0] GEN_CALL_RESET = 8'h06;

	localparam logic [7:0] PTR_TEMP = 8'h00;
	localparam logic [7:0] PTR_CONFIG = 8'h01;
	localparam logic [7:0] PTR_HIGH = 8'h02;
	localparam logic [7:0] PTR_LOW = 8'h03;
	localparam logic [7:0] PTR_UNLOCK = 8'h04;
	localparam logic [7:0] PTR_GP1 = 8'h05;
	localparam logic [7:0] PTR_GP4 = 8'h08;
	localparam logic [7:0] PTR_DEV_ID = 8'h0f;
	localparam logic [7:0] PTR_RESET = 8'h00;

	localparam logic [15:0] TEMP_RESET = 16'h8000;
	localparam logic [15:0] CONFIG_RESET = 16'h0220;
	localparam logic [15:0] HIGH_RESET = 16'h6000;
	localparam logic [15:0] LOW_RESET = 16'h8000;
	localparam logic [15:0] GP_RESET = 16'h0000;
	// Arbitrary neutral identification value.
	localparam logic [15:0] DEVICE_ID_DEF = 16'h0abc;

	localparam logic [15:0] CFG_WR_MASK = 16'h0ffc;
	localparam logic [15:0] CFG_NVM_MASK = 16'h07fc;
	localparam int CFG_BUSY_BIT = 12;
	localparam int CFG_MOD_LSB = 10;
	localparam logic [1:0] MOD_ALIAS_CC = 2'b10;
	localparam int UNLOCK_EUN_BIT = 15;
	localparam int UNLOCK_BUSY_BIT = 14;

	localparam int NVM_WORDS = 7;
	localparam logic [2:0] NVM_CFG = 3'd0;
	localparam logic [2:0] NVM_HIGH = 3'd1;
	localparam logic [2:0] NVM_LOW = 3'd2;
	localparam logic [2:0] NVM_GP1 = 3'd3;

	function automatic logic [15:0] nvm_default(input int idx);
		case (idx)
			0: nvm_default = CONFIG_RESET & CFG_NVM_MASK;
			1: nvm_default = HIGH_RESET;
			2: nvm_default = LOW_RESET;
			default: nvm_default = GP_RESET;
		endcase
	endfunction

endpackage
